// ---- verilog/hca_core.sv ----
// Execution core: fetch/execute pipeline, accumulator, ALU and flags.
// Assumes program memory and external file registers answer combinationally
// within one clock of their address; one clock, asynchronous active-low reset.
//
// Function
// RULE_01: Program fetch and file access run on separate buses in the same cycle.
// RULE_02: Each instruction is one 12-bit word fetched in one instruction cycle.
// RULE_03: Next instruction is fetched while the current one executes.
// RULE_04: All instructions take one cycle except flow changes.
// RULE_05: Taken branch discards the prefetched word, costing one extra cycle.
// RULE_06: Program counter spans 512, 1K or 2K words, all internal.
// RULE_07: Special registers including program counter low byte live in data space.
// RULE_08: Files are reachable directly or through the indirect pointer.
// RULE_09: ALU is 8 bits: add, subtract, shift and logic operations.
// RULE_10: Arithmetic treats operands and results as two's complement.
// RULE_11: Two-operand ops use accumulator and a file or literal.
// RULE_12: Single-operand ops act on accumulator or one file register.
// RULE_13: Accumulator is 8 bits and has no data-space address.
// RULE_14: ALU updates carry, nibble carry and zero per instruction.
// RULE_15: In subtraction carry and nibble carry are inverted borrows.
// RULE_16: Zero flag set on all-zero result, cleared otherwise.
// RULE_17: Low master reset holds the whole core in reset.
// RULE_18: In resistor-capacitor mode the quarter-rate output runs at clock/4.

`timescale 1ns/1ps
`default_nettype none

module hca_core
  import hca_pkg::*;
#(
  parameter int PC_W = 9
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Oscillator mode
  input wire logic resistor_capacitor_oscillator_mode,
  output logic quarter_rate_output,
  // Program bus
  output logic [PC_W-1:0] prog_addr,
  input wire logic [INSTR_W-1:0] prog_data,
  // File bus
  output hca_fbus_t fbus,
  input wire logic [DATA_W-1:0] file_rdata,
  // Observed state
  output logic [DATA_W-1:0] acc_value,
  output logic [DATA_W-1:0] status_value,
  output logic cycle_start
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  hca_phase_t ph_q;
  logic [INSTR_W-1:0] ir_q;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] stk0_q;
  logic [PC_W-1:0] stk1_q;
  logic [DATA_W-1:0] acc_q;
  logic [DATA_W-1:0] status_q;
  logic [DATA_W-1:0] fsr_q;
  logic [DATA_W-1:0] ext_q;
  hca_fbus_t fbus_q;
  logic qro_q;
  logic start_q;

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  // Literal group: the two low opcode bits pick the logic operation; move
  // and return both just pass the literal through
  function automatic logic [3:0] lit_alu_op(input logic [1:0] sel);
    logic [3:0] op;
    case (sel)
      2'h1: op = ALU_IOR;
      2'h2: op = ALU_AND;
      2'h3: op = ALU_XOR;
      default: op = ALU_PASS_B;
    endcase
    return op;
  endfunction

  // Flags a byte operation rewrites, as {zero, nibble carry, carry};
  // the skip forms leave zero alone so a loop counter keeps the flags
  function automatic logic [2:0] byte_flags(input logic [3:0] op);
    logic [2:0] fx;
    case (op)
      ALU_SUB: fx = 3'h7;
      ALU_ADD: fx = 3'h7;
      ALU_ROT_R: fx = 3'h1;
      ALU_ROT_L: fx = 3'h1;
      ALU_ZERO: fx = 3'h4;
      ALU_DEC: fx = 3'h4;
      ALU_IOR: fx = 3'h4;
      ALU_AND: fx = 3'h4;
      ALU_XOR: fx = 3'h4;
      ALU_PASS_B: fx = 3'h4;
      ALU_COM: fx = 3'h4;
      ALU_INC: fx = 3'h4;
      default: fx = 3'h0;
    endcase
    return fx;
  endfunction

  // Conditional-skip byte operations
  function automatic logic is_skip_op(input logic [3:0] op);
    return (op == ALU_DEC_SKIP) || (op == ALU_INC_SKIP);
  endfunction

  // ----------------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------------
  wire [1:0] grp = ir_q[11:10];
  wire [3:0] op4 = ir_q[9:6];
  wire [3:0] hi4 = ir_q[11:8];
  wire dbit = ir_q[5];
  wire [FILE_AW-1:0] fld = ir_q[FILE_AW-1:0];
  wire [7:0] lit8 = ir_q[7:0];
  wire [2:0] bsel = ir_q[7:5];
  wire is_byte = (grp == GRP_BYTE);
  wire is_bit = (grp == GRP_BIT);
  wire is_lit = ir_q[11];
  wire is_goto = (ir_q[11:9] == OPC_GOTO);
  wire is_call = (hi4 == OPC_CALL);
  wire is_ret = (hi4 == OPC_RETLIT);
  wire is_lit_alu = is_lit && (hi4 >= OPC_MOVLIT);

  // Indirect access goes through the pointer register
  wire [FILE_AW-1:0] eff_addr = (fld == ADDR_INDIRECT) ? fsr_q[FILE_AW-1:0] : fld; // [RULE_08]
  wire at_ind = (eff_addr == ADDR_INDIRECT);
  wire at_pcl = (eff_addr == ADDR_PCL);
  wire at_st = (eff_addr == ADDR_STATUS);
  wire at_fsr = (eff_addr == ADDR_FSR);
  wire at_ext = !(at_ind || at_pcl || at_st || at_fsr);

  // Core-resident registers answer here; the accumulator is never selectable
  wire [7:0] rd_val = at_pcl ? pc_q[7:0] : // [RULE_07] [RULE_13]
                      at_st ? status_q :
                      at_fsr ? fsr_q :
                      at_ind ? 8'h00 : ext_q;

  // Literal ops borrow the byte-op ALU codes
  wire [3:0] lit_code = lit_alu_op(hi4[1:0]);
  wire [3:0] alu_code = is_byte ? op4 : lit_code;
  wire [7:0] opb = is_lit ? lit8 : rd_val; // [RULE_11] [RULE_12]

  // ----------------------------------------------------------------------
  // ALU
  // ----------------------------------------------------------------------
  // Subtract is file plus inverted accumulator plus one, so carry-out is
  // the inverted borrow for both the byte and the low nibble
  wire do_sub = (alu_code == ALU_SUB);
  wire [7:0] acc_in = do_sub ? ~acc_q : acc_q; // [RULE_15]
  wire [8:0] sum9 = {1'b0, opb} + {1'b0, acc_in} + {8'h00, do_sub}; // [RULE_10]
  wire [4:0] sum5 = {1'b0, opb[3:0]} + {1'b0, acc_in[3:0]} + {4'h0, do_sub}; // [RULE_15]

  logic [7:0] alu_res;
  logic alu_c;

  always_comb begin // [RULE_09]
    alu_c = sum9[8];
    case (alu_code)
      ALU_PASS_A: alu_res = acc_q;
      ALU_ZERO: alu_res = 8'h00;
      ALU_SUB: alu_res = sum9[7:0];
      ALU_ADD: alu_res = sum9[7:0];
      ALU_DEC: alu_res = opb - 8'h01;
      ALU_DEC_SKIP: alu_res = opb - 8'h01;
      ALU_INC: alu_res = opb + 8'h01;
      ALU_INC_SKIP: alu_res = opb + 8'h01;
      ALU_IOR: alu_res = opb | acc_q;
      ALU_AND: alu_res = opb & acc_q;
      ALU_XOR: alu_res = opb ^ acc_q;
      ALU_PASS_B: alu_res = opb;
      ALU_COM: alu_res = ~opb;
      ALU_ROT_R: begin
        alu_res = {status_q[ST_CARRY], opb[7:1]};
        alu_c = opb[0];
      end
      ALU_ROT_L: begin
        alu_res = {opb[6:0], status_q[ST_CARRY]};
        alu_c = opb[7];
      end
      ALU_SWAP: alu_res = {opb[3:0], opb[7:4]};
      default: alu_res = opb;
    endcase
  end

  // Bit set, clear and test
  wire [7:0] bmask = 8'h01 << bsel;
  wire [7:0] bit_res = ir_q[8] ? (opb | bmask) : (opb & ~bmask);
  wire bit_val = |(opb & bmask);
  wire [7:0] result = is_bit ? bit_res : alu_res;

  // ----------------------------------------------------------------------
  // Flags and destinations
  // ----------------------------------------------------------------------
  wire [2:0] byte_fx = is_byte ? byte_flags(op4) : 3'h0;
  wire aff_z = byte_fx[2] || (is_lit_alu && hi4 != OPC_MOVLIT);
  wire aff_c = byte_fx[0];
  wire aff_dc = byte_fx[1];
  wire wr_acc = (is_byte && !dbit && op4 != 4'h0) || is_ret || is_lit_alu;
  wire wr_file = (is_byte && dbit) || (is_bit && !ir_q[9]);
  wire wr_pcl = wr_file && at_pcl;
  wire wr_st = wr_file && at_st;
  wire wr_fsr = wr_file && at_fsr;
  wire wr_ext = wr_file && at_ext;

  // A write to status keeps the read-only bits; affected flags override
  wire [7:0] st_base = wr_st ? {result[7:5], status_q[ST_RO_HI:ST_RO_LO], result[2:0]}
                             : status_q;
  logic [7:0] st_next;

  always_comb begin // [RULE_14]
    st_next = st_base;
    if (aff_z) begin
      st_next[ST_ZERO] = (alu_res == 8'h00); // [RULE_16]
    end
    if (aff_c) begin
      st_next[ST_CARRY] = alu_c; // [RULE_15]
    end
    if (aff_dc) begin
      st_next[ST_NIBBLE] = sum5[4]; // [RULE_15]
    end
  end

  // ----------------------------------------------------------------------
  // Program flow
  // ----------------------------------------------------------------------
  wire [1:0] page = status_q[ST_PAGE_HI:ST_PAGE_LO];
  wire skip = (is_byte && is_skip_op(op4) && alu_res == 8'h00) ||
              (is_bit && ir_q[9] && (bit_val == ir_q[8]));
  wire jump = is_goto || is_call || is_ret || wr_pcl;
  wire [10:0] tgt_goto = {page, ir_q[8:0]};
  wire [10:0] tgt_call = {page, 1'b0, lit8};
  wire [10:0] tgt_pcl = {page, 1'b0, result};
  wire [10:0] tgt_sel = is_goto ? tgt_goto : is_call ? tgt_call : tgt_pcl;
  // Counter width sets the program depth; upper target bits drop off
  wire [PC_W-1:0] target = is_ret ? stk0_q : tgt_sel[PC_W-1:0]; // [RULE_06]
  wire [PC_W-1:0] pc_next = jump ? target : pc_q + {{(PC_W-1){1'b0}}, 1'b1};
  // Discarding the prefetched word stretches flow changes to two cycles
  wire flush = jump || skip; // [RULE_04] [RULE_05]
  wire end_cyc = (ph_q == PH_Q4);

  // ----------------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin // [RULE_17]
      ph_q <= PH_Q1;
      start_q <= 1'b0;
    end else begin
      ph_q <= hca_phase_t'(ph_q + 2'd1);
      start_q <= end_cyc;
    end
  end

  // Quarter-rate output: high during Q3 and Q4, low in other oscillator modes
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      qro_q <= 1'b0;
    end else begin
      qro_q <= resistor_capacitor_oscillator_mode &&
               (ph_q == PH_Q2 || ph_q == PH_Q3); // [RULE_18]
    end
  end

  // ----------------------------------------------------------------------
  // Fetch pipeline
  // ----------------------------------------------------------------------
  // The program address stands for a whole instruction cycle while the
  // previous word executes; the word is taken at the end of Q4
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pc_q <= PC_RESET[PC_W-1:0];
      ir_q <= INSTR_NOP;
    end else if (end_cyc) begin
      pc_q <= pc_next; // [RULE_06]
      ir_q <= flush ? INSTR_NOP : prog_data; // [RULE_02] [RULE_03] [RULE_05]
    end
  end

  // Two-level return stack
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stk0_q <= '0;
      stk1_q <= '0;
    end else if (end_cyc && is_call) begin
      stk1_q <= stk0_q;
      stk0_q <= pc_q;
    end else if (end_cyc && is_ret) begin
      stk0_q <= stk1_q;
    end
  end

  // ----------------------------------------------------------------------
  // File bus
  // ----------------------------------------------------------------------
  // Address in Q2, data sampled at end of Q2, write strobe through Q4 only;
  // runs alongside the program fetch on its own wires
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fbus_q <= '0;
      ext_q <= 8'h00;
    end else begin
      case (ph_q)
        PH_Q1: fbus_q.addr <= eff_addr; // [RULE_01] [RULE_08]
        PH_Q2: ext_q <= file_rdata;
        PH_Q3: begin
          fbus_q.wdata <= result;
          fbus_q.we <= wr_ext; // [RULE_07]
        end
        PH_Q4: fbus_q.we <= 1'b0;
        default: fbus_q.we <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Execute commit
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      acc_q <= ACC_RESET;
      status_q <= STATUS_RESET;
      fsr_q <= FSR_RESET;
    end else if (end_cyc) begin
      if (wr_acc) begin
        acc_q <= result; // [RULE_11] [RULE_12] [RULE_13]
      end
      status_q <= st_next; // [RULE_14]
      if (wr_fsr) begin
        fsr_q <= result; // [RULE_07]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign quarter_rate_output = qro_q;
  assign prog_addr = pc_q;
  assign fbus = fbus_q;
  assign acc_value = acc_q;
  assign status_value = status_q;
  assign cycle_start = start_q;

endmodule

`default_nettype wire

// ---- inc/hca_pkg.sv ----
// Shared constants, types and bus carriers for the 8-bit execution core.
// Assumes a single clock domain and a 12-bit program word.

package hca_pkg;

  // ----------------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------------
  localparam int INSTR_W = 12;
  localparam int DATA_W = 8;
  localparam int FILE_AW = 5;
  localparam int CYCLE_CLKS = 4;

  // ----------------------------------------------------------------------
  // Core-resident file addresses
  // ----------------------------------------------------------------------
  localparam logic [FILE_AW-1:0] ADDR_INDIRECT = 5'h00;
  localparam logic [FILE_AW-1:0] ADDR_PCL = 5'h02;
  localparam logic [FILE_AW-1:0] ADDR_STATUS = 5'h03;
  localparam logic [FILE_AW-1:0] ADDR_FSR = 5'h04;

  // ----------------------------------------------------------------------
  // Status register fields and reset values
  // ----------------------------------------------------------------------
  localparam int ST_CARRY = 0;
  localparam int ST_NIBBLE = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_RO_LO = 3;
  localparam int ST_RO_HI = 4;
  localparam int ST_PAGE_LO = 5;
  localparam int ST_PAGE_HI = 6;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] FSR_RESET = 8'h00;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [10:0] PC_RESET = 11'h7ff;

  // ----------------------------------------------------------------------
  // Instruction encodings
  // ----------------------------------------------------------------------
  localparam logic [11:0] INSTR_NOP = 12'h000;
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [1:0] GRP_BIT = 2'h1;
  localparam logic [2:0] OPC_GOTO = 3'h5;
  localparam logic [3:0] OPC_RETLIT = 4'h8;
  localparam logic [3:0] OPC_CALL = 4'h9;
  localparam logic [3:0] OPC_MOVLIT = 4'hc;

  // Byte-oriented op field doubles as the ALU operation code
  typedef enum logic [3:0] {
    ALU_PASS_A = 4'h0,
    ALU_ZERO = 4'h1,
    ALU_SUB = 4'h2,
    ALU_DEC = 4'h3,
    ALU_IOR = 4'h4,
    ALU_AND = 4'h5,
    ALU_XOR = 4'h6,
    ALU_ADD = 4'h7,
    ALU_PASS_B = 4'h8,
    ALU_COM = 4'h9,
    ALU_INC = 4'ha,
    ALU_DEC_SKIP = 4'hb,
    ALU_ROT_R = 4'hc,
    ALU_ROT_L = 4'hd,
    ALU_SWAP = 4'he,
    ALU_INC_SKIP = 4'hf
  } hca_alu_e_t;

  // Four clock phases of one instruction cycle
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } hca_phase_t;

  // Data-side file bus
  typedef struct packed {
    logic [FILE_AW-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic we;
  } hca_fbus_t;

endpackage

// ---- sim/hca_mem_model.sv ----
// Far-side model: program memory and external file registers.
// Assumes the core presents one program address and one file address a cycle.
`timescale 1ns/1ps
`default_nettype none
module hca_mem_model
  import hca_pkg::*;
#(
  parameter int PC_W = 9
) (
  // Clock
  input wire logic mclk,
  // Program bus
  input wire logic [PC_W-1:0] prog_addr,
  output logic [INSTR_W-1:0] prog_data,
  // File bus
  input wire hca_fbus_t fbus,
  output logic [DATA_W-1:0] file_rdata
);
  logic [INSTR_W-1:0] rom [0:(1<<PC_W)-1];
  logic [DATA_W-1:0] files [0:31];
  // Separate read ports, so a fetch and a file access share one cycle
  assign prog_data = rom[prog_addr];
  assign file_rdata = files[fbus.addr];
  always @(posedge mclk) begin
    if (fbus.we) begin
      files[fbus.addr] <= fbus.wdata;
    end
  end
  initial begin
    for (int i = 0; i < (1 << PC_W); i++) begin
      rom[i] = INSTR_NOP;
    end
    for (int i = 0; i < 32; i++) begin
      files[i] = 8'h00;
    end
    rom[(1<<PC_W)-1] = 12'hc88;
    rom[0] = 12'h030;
    rom[1] = 12'h1d0;
    rom[2] = 12'hc89;
    rom[3] = 12'h090;
    rom[4] = 12'hc88;
    rom[5] = 12'h090;
    rom[6] = 12'h350;
    rom[7] = 12'ha0a;
    // Prefetched behind the jump; must never execute
    rom[8] = 12'hc55;
    rom[10] = 12'he0f;
    rom[11] = 12'hf01;
    rom[12] = 12'hc11;
    rom[13] = 12'h024;
    rom[14] = 12'hc5a;
    rom[15] = 12'h020;
    rom[16] = 12'h380;
    rom[17] = 12'h202;
    rom[18] = 12'h510;
    rom[19] = 12'h710;
    // Skipped by the bit test; must never execute
    rom[20] = 12'hcee;
    rom[21] = 12'h930;
    rom[22] = 12'ha16;
    rom[48] = 12'h83c;
  end
endmodule
`default_nettype wire

// ---- sim/hca_core_chk.sv ----
// Checker: cycle timing relations at the execution core's ports.
// Assumes one clock domain; bound to every core instance.
`timescale 1ns/1ps
`default_nettype none
module hca_core_chk
  import hca_pkg::*;
#(
  parameter int PC_W = 9
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Oscillator
  input wire logic resistor_capacitor_oscillator_mode,
  input wire logic quarter_rate_output,
  // Buses and state
  input wire logic [PC_W-1:0] prog_addr,
  input wire hca_fbus_t fbus,
  input wire logic [DATA_W-1:0] acc_value,
  input wire logic [DATA_W-1:0] status_value,
  input wire logic cycle_start
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  cycle_gap_a: assert property (cycle_start |=> !cycle_start [*3] ##1 cycle_start)
    else $error("instruction cycle is not four clocks");
  first_cycle_a: assert property ($rose(rst_b) |-> !cycle_start [*4] ##1 cycle_start)
    else $error("first cycle after reset misplaced");
  fetch_stands_a: assert property (cycle_start |=> $stable(prog_addr) [*3])
    else $error("program address moved inside a cycle");
  write_pulse_a: assert property (fbus.we |=> !fbus.we && cycle_start)
    else $error("file write not a single Q4 pulse");
  file_addr_a: assert property ($changed(fbus.addr) |-> $past(cycle_start))
    else $error("file address changed outside Q1 end");
  commit_a: assert property ($changed(acc_value) || $changed(status_value)
    |-> cycle_start)
    else $error("state committed outside cycle end");
  quarter_on_a: assert property (cycle_start && resistor_capacitor_oscillator_mode
    && $past(resistor_capacitor_oscillator_mode, 4) |->
    !quarter_rate_output ##1 !quarter_rate_output ##1 quarter_rate_output [*2])
    else $error("quarter rate output pattern wrong");
  quarter_off_a: assert property (!resistor_capacitor_oscillator_mode
    && !$past(resistor_capacitor_oscillator_mode) |-> !quarter_rate_output)
    else $error("quarter rate output active outside mode");
  write_cover: cover property (fbus.we);
  zero_cover: cover property ($rose(status_value[ST_ZERO]));
  quarter_cover: cover property ($rose(quarter_rate_output));
endmodule
bind hca_core hca_core_chk #(.PC_W(PC_W)) hca_core_chk_inst (.mclk(mclk), .rst_b(rst_b),
  .resistor_capacitor_oscillator_mode(resistor_capacitor_oscillator_mode),
  .quarter_rate_output(quarter_rate_output), .prog_addr(prog_addr), .fbus(fbus),
  .acc_value(acc_value), .status_value(status_value), .cycle_start(cycle_start));
`default_nettype wire

// ---- sim/harvard_core_alu_pipeline_test.sv ----
// Testbench: runs a short program and checks state after every instruction.
// Assumes the program held in the memory model.
`timescale 1ns/1ps
`default_nettype none
module harvard_core_alu_pipeline_test;
  import hca_pkg::*;
  localparam int PC_W = 9;
  logic mclk, rst_b, rcm, qro, cycle_start;
  logic [PC_W-1:0] prog_addr;
  logic [INSTR_W-1:0] prog_data;
  hca_fbus_t fbus;
  logic [DATA_W-1:0] file_rdata, acc_value, status_value;
  int mismatches, checked, cycles;
  logic [7:0] exp_acc [0:12] = '{8'h00, 8'h88, 8'h88, 8'h10, 8'h89, 8'hff, 8'h88, 8'h00,
    8'h11, 8'h11, 8'h11, 8'h01, 8'h00};
  logic [7:0] exp_st [0:12] = '{8'h18, 8'h18, 8'h18, 8'h1b, 8'h1b, 8'h18, 8'h18, 8'h1f,
    8'h1f, 8'h1f, 8'h1f, 8'h1b, 8'h1f};
  // Second stretch, one word a step: accumulator, status, program address
  logic [23:0] exp_flow [0:13] = '{24'h111f0e, 24'h111f0f, 24'h5a1f10, 24'h5a1f11,
    24'ha51f12, 24'h121b13, 24'h121b14, 24'h121b15, 24'h121b16, 24'h121b30, 24'h121b31,
    24'h3c1b16, 24'h3c1b17, 24'h3c1b16};
  hca_core #(.PC_W(PC_W)) hca_core_inst (.mclk(mclk), .rst_b(rst_b),
    .resistor_capacitor_oscillator_mode(rcm), .quarter_rate_output(qro),
    .prog_addr(prog_addr), .prog_data(prog_data), .fbus(fbus), .file_rdata(file_rdata),
    .acc_value(acc_value), .status_value(status_value), .cycle_start(cycle_start));
  hca_mem_model #(.PC_W(PC_W)) hca_mem_model_inst (.mclk(mclk), .prog_addr(prog_addr),
    .prog_data(prog_data), .fbus(fbus), .file_rdata(file_rdata));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Bounded wait for the next Q1 pulse; n counts the clocks in between
  task automatic wait_cs(output int n);
    n = 0;
    @(negedge mclk);
    while (cycle_start !== 1'b1 && n < 8) begin
      @(negedge mclk);
      n++;
    end
  endtask
  task automatic run_program();
    int n;
    for (int k = 0; k < 13; k++) begin
      wait_cs(n);
      if (k > 0) chk(16'(n), 16'h3);
      chk(16'(acc_value), 16'(exp_acc[k]));
      chk(16'(status_value), 16'(exp_st[k]));
      chk(16'(prog_addr), 16'((k < 9) ? k : k + 1));
    end
    chk(16'(hca_mem_model_inst.files[16]), 16'h88);
    $display("program test done");
  endtask
  // Pointer, indirect access, counter read, bit skip, call and return
  task automatic run_flow();
    int n;
    for (int k = 0; k < 14; k++) begin
      wait_cs(n);
      chk(16'(n), 16'(CYCLE_CLKS - 1));
      chk(16'(acc_value), 16'(exp_flow[k][23:16]));
      chk(16'(status_value), 16'(exp_flow[k][15:8]));
      chk(16'(prog_addr), 16'(exp_flow[k][7:0]));
    end
    chk(16'(hca_mem_model_inst.files[17]), 16'h5a);
    chk(16'(hca_mem_model_inst.files[16]), 16'h89);
    $display("flow test done");
  endtask
  task automatic quarter_rate();
    int n;
    wait_cs(n);
    chk(16'(qro), 16'h0);
    @(posedge mclk);
    rcm <= 1'b1;
    repeat (3) wait_cs(n);
    for (int i = 0; i < 4; i++) begin
      chk(16'(qro), (i > 1) ? 16'h1 : 16'h0);
      @(negedge mclk);
    end
    $display("quarter rate test done");
  endtask
  task automatic mid_reset();
    int n;
    @(posedge mclk);
    rst_b <= 1'b0;
    @(negedge mclk);
    chk(16'(acc_value), 16'(ACC_RESET));
    chk(16'(status_value), 16'(STATUS_RESET));
    chk(16'(prog_addr), 16'(PC_RESET[PC_W-1:0]));
    chk(16'(fbus), 16'h0);
    chk(16'({qro, cycle_start}), 16'h0);
    @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) wait_cs(n);
    chk(16'(acc_value), 16'h88);
    $display("reset test done");
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 1000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    rst_b = 1'b0;
    rcm = 1'b0;
    mismatches = 0;
    checked = 0;
    cycles = 0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    run_program();
    run_flow();
    quarter_rate();
    mid_reset();
    close_out();
  end
endmodule
`default_nettype wire
